// *** fssr_cfg.svh ***
// constants for the flash suspend/resume control ends
`ifndef FSSR_CFG_SVH
`define FSSR_CFG_SVH
`define FSSR_CLK_NS        50
`define FSSR_SUSP_LAT_NS   40000
`define FSSR_RSM_GAP_NS    100000
`define FSSR_SUSP_LAT_CYC  (`FSSR_SUSP_LAT_NS / `FSSR_CLK_NS)
`define FSSR_RSM_GAP_CYC   ((`FSSR_RSM_GAP_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)
`define FSSR_PROG_CYC      200
`define FSSR_ERASE_CYC     1000
`define FSSR_CHIP_CYC      4000
`define FSSR_CRC_CYC       500
`define FSSR_SR1_BUSY      0
`define FSSR_SR1_WEL       1
`define FSSR_SR2_PROG      0
`define FSSR_SR2_ERASE     1
`define FSSR_SR2_CRC       4
`define FSSR_UNDEF_BYTE    8'hA5
`define FSSR_REG_CMD       8'h00
`define FSSR_REG_ADDR      8'h04
`define FSSR_REG_STATUS    8'h08
`define FSSR_REG_RDATA     8'h0C
`define FSSR_ST_PEND       0
`define FSSR_ST_OK         1
`define FSSR_ST_DEF        2
`define FSSR_ST_HALTED     3
`endif

// *** fssr_pkg.sv ***
// types shared by both ends of the suspend/resume link
package fssr_pkg;
    typedef enum logic [3:0] {
        OP_NOP, OP_RD_SR1, OP_RD_SR2, OP_RD_ARRAY, OP_RD_DYB, OP_WREN, OP_WRDIS, OP_PAGE_PROG,
        OP_SEC_PROG, OP_SECT_ERASE, OP_CHIP_ERASE, OP_CRC_START, OP_WR_ANY_REG, OP_ERASE_PPB,
        OP_SUSPEND, OP_RESUME
    } fssr_op_t;
    typedef enum logic [2:0] {ENG_IDLE, ENG_PROG, ENG_ERASE, ENG_CHIP, ENG_CRC, ENG_SUSPENDING} fssr_eng_t;
    typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAIT, H_POLL, H_POLL_WAIT} fssr_host_st_t;
endpackage : fssr_pkg

// *** fssr_if.sv ***
// transaction link between host controller and flash device
`timescale 1ns/1ps
interface fssr_if;
    import fssr_pkg::*;
    logic       req;
    fssr_op_t   op;
    logic [15:0] addr;
    logic       ack;
    logic       ok;
    logic [7:0] rdata;
    logic       rdef;
    modport dev  (input req, input op, input addr, output ack, output ok, output rdata, output rdef);
    modport host (output req, output op, output addr, input ack, input ok, input rdata, input rdef);
endinterface : fssr_if

// *** fssr_device.sv ***
// flash device end: embedded operation engine with suspend and resume
// What this block does
// - suspend halts operation, busy clears; host polls
// - program suspend only while programming runs
// - status2 bit 0 shows program suspended
// - reads in suspended page give undefined data
// - erase suspend only for sector erase
// - status2 bit 1 shows erase suspended
// - erase suspend allows program, read, protection read
// - new erase ignored while anything suspended
// - reads in suspended sector give undefined data
// - integrity suspend only during crc; reads allowed
// - status2 bit 4 shows integrity check suspended
// - register write, protection erase refused when suspended
// - suspend completes within suspend latency
// - program in erase suspend returns to it
// - only defined transaction subset accepted while suspended
// - resume sets busy, program before erase
// - resume ignored when nothing suspended
// - suspend and resume repeatable without limit
// - host waits minimum gap resume to suspend
// - host should protect such sectors by dynamic bits; here they are fixed by DYB_INIT and block no program or erase
// - busy held through embedded operation
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "fssr_cfg.svh"
module fssr_device
    import fssr_pkg::*;
#(
    parameter int          CNT_W      = 16,
    parameter int          SUSP_LAT   = `FSSR_SUSP_LAT_CYC,
    parameter int          PROG_CYC   = `FSSR_PROG_CYC,
    parameter int          ERASE_CYC  = `FSSR_ERASE_CYC,
    parameter int          CHIP_CYC   = `FSSR_CHIP_CYC,
    parameter int          CRC_CYC    = `FSSR_CRC_CYC,
    parameter logic [15:0] DYB_INIT   = 16'h0000
) (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    fssr_if.dev         link,
    output logic        ready_busy_o,
    output logic [2:0]  suspended_o
);
    fssr_eng_t          run_q, run_d, kind_q, kind_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d, prog_left_q, prog_left_d;
    logic [CNT_W-1:0]   erase_left_q, erase_left_d, crc_left_q, crc_left_d;
    logic               prog_s_q, prog_s_d, erase_s_q, erase_s_d, crc_s_q, crc_s_d;
    logic               wel_q, wel_d;
    logic [7:0]         ppage_q, ppage_d;
    logic [3:0]         esect_q, esect_d;
    logic               ack_q, ok_q, rdef_q;
    logic [7:0]         rdata_q;

    wire logic busy      = (run_q != ENG_IDLE);
    wire logic any_susp  = prog_s_q | erase_s_q | crc_s_q;
    wire logic ps_cs     = prog_s_q | crc_s_q;
    wire logic can_susp  = ((run_q == ENG_PROG) || (run_q == ENG_ERASE) || (run_q == ENG_CRC))
                           && !ps_cs && (cnt_q > 1);
    wire logic in_ppage  = prog_s_q && (link.addr[15:8] == ppage_q);
    wire logic in_esect  = erase_s_q && (link.addr[15:12] == esect_q);
    logic            accept;
    wire logic [7:0] sr1 = 8'(wel_q) << `FSSR_SR1_WEL | 8'(busy) << `FSSR_SR1_BUSY;
    wire logic [7:0] sr2 = 8'(prog_s_q) << `FSSR_SR2_PROG | 8'(erase_s_q) << `FSSR_SR2_ERASE
                         | 8'(crc_s_q) << `FSSR_SR2_CRC;
    wire logic arr_def   = !in_ppage && !in_esect;
    wire logic [7:0] arr = arr_def ? (link.addr[7:0] ^ link.addr[15:8]) : `FSSR_UNDEF_BYTE;
    wire logic [7:0] dynamic_protection_bits = {7'h00, DYB_INIT[link.addr[15:12]]};

    // acceptance filter; while busy only status reads and a valid suspend get through
    function automatic logic fssr_allowed(input fssr_op_t op);
        logic r;
        r = 1'b0;
        case (op)
            OP_RD_SR1, OP_RD_SR2: r = 1'b1;
            OP_SUSPEND:    r = can_susp;
            OP_RESUME:     r = !busy && any_susp;
            OP_RD_ARRAY, OP_RD_DYB: r = !busy;
            OP_WREN, OP_WRDIS: r = !busy && !ps_cs;
            OP_PAGE_PROG, OP_SEC_PROG: r = !busy && !ps_cs && wel_q
                                           && !(erase_s_q && link.addr[15:12] == esect_q);
            OP_SECT_ERASE, OP_CHIP_ERASE: r = !busy && !any_susp && wel_q;
            OP_CRC_START:  r = !busy && !any_susp;
            OP_WR_ANY_REG, OP_ERASE_PPB: r = !busy && !any_susp && wel_q;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction : fssr_allowed

    // a continuous assignment would only wake on op changes and miss state read inside the function
    always_comb accept = fssr_allowed(link.op);

    always_comb begin
        run_d        = run_q;
        kind_d       = kind_q;
        cnt_d        = cnt_q;
        prog_left_d  = prog_left_q;
        erase_left_d = erase_left_q;
        crc_left_d   = crc_left_q;
        prog_s_d     = prog_s_q;
        erase_s_d    = erase_s_q;
        crc_s_d      = crc_s_q;
        wel_d        = wel_q;
        ppage_d      = ppage_q;
        esect_d      = esect_q;
        if (run_q == ENG_SUSPENDING) begin
            if (cnt_q <= 1) begin
                run_d = ENG_IDLE;
                case (kind_q)
                    ENG_PROG:  prog_s_d = 1'b1;
                    ENG_ERASE: erase_s_d = 1'b1;
                    ENG_CRC:   crc_s_d = 1'b1;
                    default:   ;
                endcase
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end else if (busy) begin
            // completion leaves the flag clear; a program nested in erase suspend keeps erase flag
            if (cnt_q <= 1) begin
                run_d = ENG_IDLE;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        if (link.req && accept) begin
            case (link.op)
                OP_SUSPEND: begin
                    run_d  = ENG_SUSPENDING;
                    kind_d = run_q;
                    cnt_d  = CNT_W'(SUSP_LAT);
                    case (run_q)
                        ENG_PROG:  prog_left_d = cnt_q - 1'b1;
                        ENG_ERASE: erase_left_d = cnt_q - 1'b1;
                        default:   crc_left_d = cnt_q - 1'b1;
                    endcase
                end
                OP_RESUME: begin
                    if (prog_s_q) begin
                        run_d    = ENG_PROG;
                        cnt_d    = prog_left_q;
                        prog_s_d = 1'b0;
                    end else if (erase_s_q) begin
                        run_d     = ENG_ERASE;
                        cnt_d     = erase_left_q;
                        erase_s_d = 1'b0;
                    end else begin
                        run_d   = ENG_CRC;
                        cnt_d   = crc_left_q;
                        crc_s_d = 1'b0;
                    end
                end
                OP_WREN:  wel_d = 1'b1;
                OP_WRDIS: wel_d = 1'b0;
                OP_PAGE_PROG, OP_SEC_PROG: begin
                    run_d   = ENG_PROG;
                    cnt_d   = CNT_W'(PROG_CYC);
                    wel_d   = 1'b0;
                    ppage_d = link.addr[15:8];
                end
                OP_SECT_ERASE: begin
                    run_d   = ENG_ERASE;
                    cnt_d   = CNT_W'(ERASE_CYC);
                    wel_d   = 1'b0;
                    esect_d = link.addr[15:12];
                end
                OP_CHIP_ERASE: begin
                    run_d = ENG_CHIP;
                    cnt_d = CNT_W'(CHIP_CYC);
                    wel_d = 1'b0;
                end
                OP_CRC_START: begin
                    run_d = ENG_CRC;
                    cnt_d = CNT_W'(CRC_CYC);
                end
                OP_WR_ANY_REG, OP_ERASE_PPB: wel_d = 1'b0;
                default: ;
            endcase
        end
    end

    // response data; array content is a stand-in pattern, storage is outside this block
    wire logic [7:0] rsp_data = (link.op == OP_RD_SR1)   ? sr1 :
                                (link.op == OP_RD_SR2)   ? sr2 :
                                (link.op == OP_RD_ARRAY) ? arr :
                                (link.op == OP_RD_DYB)   ? dynamic_protection_bits : 8'h00;
    wire logic rsp_def = (link.op == OP_RD_ARRAY) ? arr_def : 1'b1;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_q        <= ENG_IDLE;
            kind_q       <= ENG_IDLE;
            cnt_q        <= '0;
            prog_left_q  <= '0;
            erase_left_q <= '0;
            crc_left_q   <= '0;
            prog_s_q     <= 1'b0;
            erase_s_q    <= 1'b0;
            crc_s_q      <= 1'b0;
            wel_q        <= 1'b0;
            ppage_q      <= 8'h00;
            esect_q      <= 4'h0;
        end else begin
            run_q        <= run_d;
            kind_q       <= kind_d;
            cnt_q        <= cnt_d;
            prog_left_q  <= prog_left_d;
            erase_left_q <= erase_left_d;
            crc_left_q   <= crc_left_d;
            prog_s_q     <= prog_s_d;
            erase_s_q    <= erase_s_d;
            crc_s_q      <= crc_s_d;
            wel_q        <= wel_d;
            ppage_q      <= ppage_d;
            esect_q      <= esect_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            ok_q    <= 1'b0;
            rdata_q <= 8'h00;
            rdef_q  <= 1'b0;
            ready_busy_o <= 1'b0;
            suspended_o  <= 3'h0;
        end else begin
            ack_q   <= link.req;
            ok_q    <= link.req && accept;
            rdata_q <= (link.req && accept) ? rsp_data : 8'h00;
            rdef_q  <= link.req && accept && rsp_def;
            ready_busy_o <= (run_d != ENG_IDLE);
            suspended_o  <= {crc_s_d, erase_s_d, prog_s_d};
        end
    end

    assign link.ack   = ack_q;
    assign link.ok    = ok_q;
    assign link.rdata = rdata_q;
    assign link.rdef  = rdef_q;
endmodule : fssr_device

// *** fssr_host.sv ***
// host controller end: software command port, suspend pacing and busy polling
`timescale 1ns/1ps
`include "fssr_cfg.svh"
module fssr_host
    import fssr_pkg::*;
#(
    parameter int CNT_W   = 16,
    parameter int RSM_GAP = `FSSR_RSM_GAP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  sw_addr_i,
    input  wire logic [31:0] sw_wdata_i,
    input  wire logic        sw_wr_i,
    input  wire logic        sw_rd_i,
    output logic [31:0]      sw_rdata_o,
    fssr_if.host             link
);
    fssr_host_st_t    st_q;
    fssr_op_t         op_q, lop_q;
    logic [15:0]      addr_q, laddr_q;
    logic             req_q, ok_q, def_q, halted_q;
    logic [7:0]       rdata_q;
    logic [CNT_W-1:0] gap_q;

    wire logic       pend     = (st_q != H_IDLE);
    wire logic       cmd_wr   = sw_wr_i && (sw_addr_i == `FSSR_REG_CMD) && !pend;
    wire logic       gap_hold = (op_q == OP_SUSPEND) && (gap_q != 0);
    wire logic [31:0] status  = 32'(pend) << `FSSR_ST_PEND | 32'(ok_q) << `FSSR_ST_OK
                              | 32'(def_q) << `FSSR_ST_DEF | 32'(halted_q) << `FSSR_ST_HALTED;
    wire logic [31:0] rd_mux  = (sw_addr_i == `FSSR_REG_ADDR)   ? {16'h0000, addr_q} :
                                (sw_addr_i == `FSSR_REG_STATUS) ? status :
                                (sw_addr_i == `FSSR_REG_RDATA)  ? {24'h000000, rdata_q} : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sw_rdata_o <= 32'h00000000;
            addr_q     <= 16'h0000;
        end else begin
            sw_rdata_o <= sw_rd_i ? rd_mux : 32'h00000000;
            if (sw_wr_i && (sw_addr_i == `FSSR_REG_ADDR)) begin
                addr_q <= sw_wdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q     <= H_IDLE;
            op_q     <= OP_NOP;
            lop_q    <= OP_NOP;
            laddr_q  <= 16'h0000;
            req_q    <= 1'b0;
            ok_q     <= 1'b0;
            def_q    <= 1'b0;
            halted_q <= 1'b0;
            rdata_q  <= 8'h00;
            gap_q    <= '0;
        end else begin
            req_q <= 1'b0;
            if (gap_q != 0) begin
                gap_q <= gap_q - 1'b1;
            end
            case (st_q)
                H_IDLE: begin
                    if (cmd_wr) begin
                        op_q     <= fssr_op_t'(sw_wdata_i[3:0]);
                        halted_q <= 1'b0;
                        st_q     <= H_SEND;
                    end
                end
                H_SEND: begin
                    // a suspend too soon after resume would starve the operation
                    if (!gap_hold) begin
                        req_q   <= 1'b1;
                        lop_q   <= op_q;
                        laddr_q <= addr_q;
                        st_q    <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (link.ack) begin
                        ok_q    <= link.ok;
                        def_q   <= link.rdef;
                        rdata_q <= link.rdata;
                        if (op_q == OP_RESUME && link.ok) begin
                            gap_q <= CNT_W'(RSM_GAP);
                        end
                        st_q <= (op_q == OP_SUSPEND && link.ok) ? H_POLL : H_IDLE;
                    end
                end
                H_POLL: begin
                    req_q <= 1'b1;
                    lop_q <= OP_RD_SR1;
                    st_q  <= H_POLL_WAIT;
                end
                H_POLL_WAIT: begin
                    if (link.ack) begin
                        if (!link.rdata[`FSSR_SR1_BUSY]) begin
                            halted_q <= 1'b1;
                            st_q     <= H_IDLE;
                        end else begin
                            st_q <= H_POLL;
                        end
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.req  = req_q;
    assign link.op   = lop_q;
    assign link.addr = laddr_q;
endmodule : fssr_host

// *** fssr_properties.sv ***
// concurrent checks on the link between host and device ends
`timescale 1ns/1ps
module fssr_properties
    import fssr_pkg::*;
#(
    parameter int SUSP_LAT = 4
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       req,
    input fssr_op_t        op,
    input wire logic       ack,
    input wire logic       ok,
    input wire logic [7:0] rdata,
    input wire logic       ready_busy_o,
    input wire logic [2:0] suspended_o
);
    // two cycles of slack: busy may fall counted from the request or the answer
    localparam int LAT_HI = SUSP_LAT + 2;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_susp_acc;
        req && op == OP_SUSPEND ##1 ack && ok;
    endsequence
    sequence s_rsm_acc;
        req && op == OP_RESUME ##1 ack && ok;
    endsequence
    a_ack_answer: assert property (req |=> ack)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("answer without request");
    a_suspend_halts: assert property (s_susp_acc |-> ##[1:LAT_HI] (!ready_busy_o && suspended_o != 3'b000))
        else $error("suspend did not halt in time");
    a_resume_busy: assert property (s_rsm_acc |-> ready_busy_o)
        else $error("busy not set on resume");
    a_resume_ignored: assert property (req && op == OP_RESUME && suspended_o == 3'b000 |=> ack && !ok)
        else $error("resume accepted with nothing suspended");
    a_erase_blocked: assert property (req && (op == OP_SECT_ERASE || op == OP_CHIP_ERASE)
        && suspended_o != 3'b000 |=> !ok)
        else $error("erase accepted while suspended");
    a_regwr_refused: assert property (req && (op == OP_WR_ANY_REG || op == OP_ERASE_PPB)
        && suspended_o != 3'b000 |=> !ok)
        else $error("protection change accepted while suspended");
    a_prog_subset: assert property (req && (op == OP_WREN || op == OP_PAGE_PROG || op == OP_SEC_PROG)
        && (suspended_o[0] || suspended_o[2]) |=> !ok)
        else $error("refused transaction accepted in suspend");
    a_refused_zero: assert property (ack && !ok |-> rdata == 8'h00)
        else $error("refused answer carries data");
    a_busy_cause: assert property ($rose(ready_busy_o) |-> ack && ok)
        else $error("busy rose without accepted request");
endmodule : fssr_properties

// *** flash_suspend_resume_control_bench.sv ***
// testbench joining host and device ends through the link
`timescale 1ns/1ps
`include "fssr_cfg.svh"
module flash_suspend_resume_control_bench;
    import fssr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  sw_addr_i = 8'h00;
    logic [31:0] sw_wdata_i = 32'h0;
    logic        sw_wr_i = 1'b0;
    logic        sw_rd_i = 1'b0;
    logic [31:0] sw_rdata_o;
    logic        ready_busy;
    logic [2:0]  susp;
    logic        r_def;
    logic        r_halt;
    logic [7:0]  r_dat;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    fssr_op_t    bad [4] = '{OP_SECT_ERASE, OP_CHIP_ERASE, OP_WR_ANY_REG, OP_ERASE_PPB};
    fssr_if lnk();
    // chip erase and integrity check run at their default lengths
    fssr_device #(.SUSP_LAT(4), .PROG_CYC(100), .ERASE_CYC(300),
        .DYB_INIT(16'h0004)) i_fssr_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk.dev),
        .ready_busy_o(ready_busy), .suspended_o(susp));
    fssr_host #(.RSM_GAP(5)) i_fssr_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .sw_addr_i(sw_addr_i),
        .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
        .link(lnk.host));
    // checker latency default equals the device override above
    fssr_properties i_fssr_properties (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req(lnk.req), .op(lnk.op), .ack(lnk.ack), .ok(lnk.ok), .rdata(lnk.rdata),
        .ready_busy_o(ready_busy), .suspended_o(susp));
    always #25 clk_i = ~clk_i;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // the ceiling is far above the few thousand cycles the sequence needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        sw_addr_i  <= a;
        sw_wdata_i <= d;
        sw_wr_i    <= 1'b1;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_rd_i   <= 1'b1;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1;
        d = sw_rdata_o;
    endtask : sw_rd
    // one link transaction through the host; compares the accept flag
    task automatic issue(input fssr_op_t op, input logic [15:0] a, input logic eok);
        logic [31:0] st;
        int          n;
        sw_wr(`FSSR_REG_ADDR, {16'h0000, a});
        sw_wr(`FSSR_REG_CMD, {28'h0000000, op});
        n  = 0;
        st = 32'h1;
        while (st[0] !== 1'b0 && n < 200) begin
            sw_rd(`FSSR_REG_STATUS, st);
            n++;
        end
        chk(st[1:0], {eok, 1'b0});
        r_def  = st[2];
        r_halt = st[3];
        sw_rd(`FSSR_REG_RDATA, st);
        r_dat = st[7:0];
    endtask : issue
    task automatic wait_idle();
        int n;
        n     = 0;
        r_dat = 8'h01;
        while (r_dat[0] !== 1'b0 && n < 400) begin
            issue(OP_RD_SR1, 16'h0000, 1'b1);
            n++;
        end
        chk(r_dat[0], 1'b0);
    endtask : wait_idle
    task automatic sr2(input logic [7:0] exp);
        issue(OP_RD_SR2, 16'h0000, 1'b1);
        chk(r_dat, exp);
    endtask : sr2
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        issue(OP_RD_SR1, 16'h0000, 1'b1);
        chk(r_dat[1:0], 2'b00);
        issue(OP_RESUME, 16'h0000, 1'b0);
        issue(OP_SUSPEND, 16'h0000, 1'b0);
        // sector erase, then suspend it
        issue(OP_WREN, 16'h0000, 1'b1);
        issue(OP_SECT_ERASE, 16'h1000, 1'b1);
        issue(OP_RD_SR1, 16'h0000, 1'b1);
        chk(r_dat[0], 1'b1);
        issue(OP_RD_ARRAY, 16'h2345, 1'b0);
        issue(OP_SUSPEND, 16'h0000, 1'b1);
        chk(r_halt, 1'b1);
        sr2(8'h02);
        issue(OP_RD_ARRAY, 16'h1234, 1'b1);
        chk({r_def, r_dat}, {1'b0, `FSSR_UNDEF_BYTE});
        issue(OP_RD_ARRAY, 16'h2345, 1'b1);
        chk({r_def, r_dat}, 9'h166);
        issue(OP_RD_DYB, 16'h2000, 1'b1);
        chk(r_dat, 8'h01);
        issue(OP_WRDIS, 16'h0000, 1'b1);
        issue(OP_WREN, 16'h0000, 1'b1);
        foreach (bad[i]) issue(bad[i], 16'h3000, 1'b0);
        issue(OP_WREN, 16'h0000, 1'b1);
        issue(OP_PAGE_PROG, 16'h2300, 1'b1);
        issue(OP_SUSPEND, 16'h0000, 1'b1);
        sr2(8'h03);
        issue(OP_WREN, 16'h0000, 1'b0);
        issue(OP_PAGE_PROG, 16'h2300, 1'b0);
        issue(OP_SEC_PROG, 16'h2300, 1'b0);
        issue(OP_RD_ARRAY, 16'h2311, 1'b1);
        chk(r_def, 1'b0);
        issue(OP_RESUME, 16'h0000, 1'b1);
        issue(OP_RD_SR1, 16'h0000, 1'b1);
        chk(r_dat[0], 1'b1);
        wait_idle();
        sr2(8'h02);
        issue(OP_RESUME, 16'h0000, 1'b1);
        wait_idle();
        sr2(8'h00);
        issue(OP_RESUME, 16'h0000, 1'b0);
        // integrity check, suspended twice across a resume
        // write enable set first so the erase below is refused only for the suspend
        issue(OP_WREN, 16'h0000, 1'b1);
        issue(OP_CRC_START, 16'h0000, 1'b1);
        issue(OP_SUSPEND, 16'h0000, 1'b1);
        sr2(8'h10);
        issue(OP_RD_ARRAY, 16'h0102, 1'b1);
        chk({r_def, r_dat}, 9'h103);
        issue(OP_SECT_ERASE, 16'h1000, 1'b0);
        issue(OP_WREN, 16'h0000, 1'b0);
        issue(OP_RESUME, 16'h0000, 1'b1);
        issue(OP_SUSPEND, 16'h0000, 1'b1);
        sr2(8'h10);
        issue(OP_RESUME, 16'h0000, 1'b1);
        wait_idle();
        sr2(8'h00);
        // whole-chip erase cannot be suspended
        issue(OP_WREN, 16'h0000, 1'b1);
        issue(OP_CHIP_ERASE, 16'h0000, 1'b1);
        issue(OP_SUSPEND, 16'h0000, 1'b0);
        wait_idle();
        sr2(8'h00);
        end_of_test();
    end
endmodule : flash_suspend_resume_control_bench
